// ---- verilog/ttr_reporter.sv ----
// Triggered tag read control, completion pulse and telegram transmitter
`timescale 1ns/100ps
`default_nettype none

module ttr_reporter #(
  parameter int unsigned READ_CYCLE_CYC_P = ttr_pkg::READ_CYCLE_CYC,
  parameter int unsigned PULSE_CYC_P      = ttr_pkg::PULSE_CYC,
  parameter int unsigned DEBOUNCE_CYC_P   = ttr_pkg::DEBOUNCE_CYC,
  parameter int unsigned BIT_CYC_P        = ttr_pkg::BIT_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   trigger_input_a_i,
  input  wire logic                   trigger_input_b_i,
  input  wire ttr_pkg::ttr_host_cmd_t host_cmd_i,
  input  wire ttr_pkg::ttr_cfg_t      cfg_i,
  input  wire ttr_pkg::ttr_tag_t      tag_i,
  input  wire logic                   self_check_pass_i,
  output logic                        read_active_o,
  output logic                        antenna_sel_o,
  output logic                        read_done_pulse_o,
  output logic                        ser_tx_o
);

  typedef logic [ttr_pkg::CNT_W-1:0] ttr_cnt_t;

  localparam ttr_cnt_t RD_CYC  = ttr_cnt_t'(READ_CYCLE_CYC_P);
  localparam ttr_cnt_t PLS_CYC = ttr_cnt_t'(PULSE_CYC_P);
  localparam ttr_cnt_t DEB_CYC = ttr_cnt_t'(DEBOUNCE_CYC_P);
  localparam ttr_cnt_t BT_CYC  = ttr_cnt_t'(BIT_CYC_P);
  localparam ttr_cnt_t ONE     = ttr_cnt_t'(1);

  typedef struct packed {
    logic [1:0]                      sync1;
    logic [1:0]                      sync2;
    logic [1:0]                      trig;
    logic [1:0][ttr_pkg::CNT_W-1:0]  deb_cnt;
    ttr_pkg::ttr_rd_state_t          rd;
    logic                            ant;
    logic [ttr_pkg::CNT_W-1:0]       cyc_cnt;
    logic                            first_cycle;
    logic                            stop_pend;
    logic                            have_code;
    logic [63:0]                     code;
    logic                            pulse;
    logic [ttr_pkg::CNT_W-1:0]       pulse_cnt;
    logic                            poc_pend;
    logic                            tel_pend;
    logic                            msg_busy;
    logic                            msg_poc;
    logic                            poc_ok;
    logic [4:0]                      char_idx;
    ttr_pkg::ttr_tx_state_t          tx;
    logic [9:0]                      shreg;
    logic [3:0]                      bit_idx;
    logic [ttr_pkg::CNT_W-1:0]       baud_cnt;
    logic                            txd;
  } ttr_state_t;

  localparam ttr_state_t ST_RST = '{
    rd:       ttr_pkg::RD_IDLE,
    tx:       ttr_pkg::TX_IDLE,
    txd:      1'b1,
    poc_pend: 1'b1,
    default:  '0
  };

  ttr_state_t q;
  ttr_state_t n;

  // Character at a message position
  function automatic logic [7:0] msg_char(
    input logic        power_on_self_check,
    input logic        poc_ok,
    input logic [4:0]  idx,
    input logic [4:0]  len,
    input logic        have_code,
    input logic [63:0] code
  );
    logic [111:0] text;
    logic [4:0]   nib_idx;
    logic [63:0]  shifted;
    logic [3:0]   nib;
    logic [7:0]   ch;
    text    = poc_ok ? ttr_pkg::POC_PASS_TEXT : ttr_pkg::POC_FAIL_TEXT;
    nib_idx = 5'(len - 5'h03 - idx);
    shifted = code >> {nib_idx, 2'b00};
    nib     = shifted[3:0];
    ch      = ttr_pkg::CHAR_CR;
    if (idx == 5'(len - 5'h01)) begin
      ch = ttr_pkg::CHAR_LF;
    end else if (idx == 5'(len - 5'h02)) begin
      ch = ttr_pkg::CHAR_CR;
    end else if (power_on_self_check) begin
      ch = text[8 * (ttr_pkg::POC_TEXT_LEN - 5'h01 - idx) +: 8];
    end else if (!have_code) begin
      ch = ttr_pkg::CHAR_QMARK;
    end else if (nib > ttr_pkg::NIBBLE_NINE) begin
      ch = 8'(nib) + ttr_pkg::CHAR_ALPHA_OFS;
    end else begin
      ch = 8'(nib) + ttr_pkg::CHAR_ZERO;
    end
    return ch;
  endfunction : msg_char

  always_comb begin
    logic [1:0]                rise;
    logic [1:0]                fall;
    logic [1:0]                bsel;
    logic [ttr_pkg::CNT_W-1:0] bit_cyc;
    logic [4:0]                len;
    logic                      cyc_end;
    rise    = 2'b00;
    fall    = 2'b00;
    len     = '0;
    cyc_end = 1'b0;
    bsel    = (cfg_i.baud_sel > ttr_pkg::BAUD_SEL_MAX) ? ttr_pkg::BAUD_SEL_MAX
                                                       : cfg_i.baud_sel;
    bit_cyc = BT_CYC >> bsel;
    n       = q;

    // Two stage synchroniser then debounce
    n.sync1 = {trigger_input_b_i, trigger_input_a_i};
    n.sync2 = q.sync1;
    for (int k = 0; k < 2; k++) begin
      if (q.sync2[k] == q.trig[k]) begin
        n.deb_cnt[k] = '0;
      end else if (q.deb_cnt[k] >= DEB_CYC - ONE) begin
        n.deb_cnt[k] = '0;
        n.trig[k]    = q.sync2[k];
        rise[k]      = q.sync2[k];
        fall[k]      = ~q.sync2[k];
      end else begin
        n.deb_cnt[k] = q.deb_cnt[k] + ONE;
      end
    end

    // Read control
    cyc_end = (q.cyc_cnt == RD_CYC - ONE);
    case (q.rd)
      ttr_pkg::RD_IDLE: begin
        if (rise[0] || rise[1] || host_cmd_i.start) begin
          n.rd          = ttr_pkg::RD_ACTIVE;
          n.ant         = ~rise[0] & rise[1];
          n.cyc_cnt     = '0;
          n.first_cycle = 1'b1;
          n.stop_pend   = 1'b0;
          n.have_code   = 1'b0;
        end
      end
      ttr_pkg::RD_ACTIVE: begin
        n.cyc_cnt = cyc_end ? '0 : q.cyc_cnt + ONE;
        if (cyc_end) begin
          n.first_cycle = 1'b0;
        end
        if (tag_i.valid) begin
          n.rd        = ttr_pkg::RD_IDLE;
          n.have_code = 1'b1;
          n.code      = tag_i.code;
        end else if (fall[0] || fall[1]) begin
          n.rd = ttr_pkg::RD_IDLE;
        end else if (cyc_end && q.stop_pend) begin
          n.rd = ttr_pkg::RD_IDLE;
        end else if (host_cmd_i.stop) begin
          if (q.first_cycle && !cyc_end) begin
            n.stop_pend = 1'b1;
          end else begin
            n.rd = ttr_pkg::RD_IDLE;
          end
        end
      end
      default: begin
        n.rd = ttr_pkg::RD_IDLE;
      end
    endcase

    // Completion pulse, length scaled by bit rate
    if (q.pulse) begin
      n.pulse_cnt = q.pulse_cnt - ONE;
      if (q.pulse_cnt <= ONE) begin
        n.pulse = 1'b0;
      end
    end
    if (fall[0] || fall[1]) begin
      n.pulse     = 1'b1;
      n.pulse_cnt = PLS_CYC >> bsel;
    end

    // Message sequencer
    len = q.msg_poc ? ttr_pkg::POC_MSG_LEN
                    : 5'(ttr_pkg::CODE_LEN_BASE + 5'(cfg_i.code_length_param) + 5'h02);
    if (!q.msg_busy && q.tx == ttr_pkg::TX_IDLE) begin
      if (q.poc_pend) begin
        n.msg_busy = 1'b1;
        n.msg_poc  = 1'b1;
        n.poc_ok   = self_check_pass_i;
        n.char_idx = '0;
        n.poc_pend = 1'b0;
      end else if (q.tel_pend) begin
        n.msg_busy = 1'b1;
        n.msg_poc  = 1'b0;
        n.char_idx = '0;
        n.tel_pend = 1'b0;
      end
    end
    if (fall[0] && !cfg_i.protocol_mode) begin
      n.tel_pend = 1'b1;
    end
    if (host_cmd_i.scan && cfg_i.protocol_mode) begin
      n.tel_pend = 1'b1;
    end

    // Serial transmitter, free running without handshake
    case (q.tx)
      ttr_pkg::TX_IDLE: begin
        n.txd = 1'b1;
        if (q.msg_busy) begin
          n.shreg    = {1'b1,
                        msg_char(q.msg_poc, q.poc_ok, q.char_idx, len, q.have_code, q.code),
                        1'b0};
          n.txd      = 1'b0;
          n.tx       = ttr_pkg::TX_SHIFT;
          n.bit_idx  = '0;
          n.baud_cnt = '0;
          if (q.char_idx == 5'(len - 5'h01)) begin
            n.msg_busy = 1'b0;
          end else begin
            n.char_idx = q.char_idx + 5'h01;
          end
        end
      end
      ttr_pkg::TX_SHIFT: begin
        n.baud_cnt = q.baud_cnt + ONE;
        if (q.baud_cnt >= bit_cyc - ONE) begin
          n.baud_cnt = '0;
          if (q.bit_idx == ttr_pkg::FRAME_LAST_BIT) begin
            n.tx  = ttr_pkg::TX_IDLE;
            n.txd = 1'b1;
          end else begin
            n.bit_idx = q.bit_idx + 4'h1;
            n.shreg   = {1'b1, q.shreg[9:1]};
            n.txd     = q.shreg[1];
          end
        end
      end
      default: begin
        n.tx  = ttr_pkg::TX_IDLE;
        n.txd = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign read_active_o     = (q.rd == ttr_pkg::RD_ACTIVE);
  assign antenna_sel_o     = q.ant;
  assign read_done_pulse_o = q.pulse;
  assign ser_tx_o          = q.txd;

endmodule : ttr_reporter

`default_nettype wire

// ---- verilog/ttr_pkg.sv ----
// Constants and types for the triggered tag read reporter
package ttr_pkg;

  localparam int unsigned CNT_W          = 24;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned READ_CYCLE_MS  = 50;
  localparam int unsigned READ_CYCLE_CYC = CLK_HZ / 1000 * READ_CYCLE_MS;
  localparam int unsigned PULSE_MS       = 12;
  localparam int unsigned PULSE_CYC      = CLK_HZ / 1000 * PULSE_MS;
  localparam int unsigned DEBOUNCE_US    = 1000;
  localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int unsigned BASE_BAUD      = 9600;
  localparam int unsigned BIT_CYC        = CLK_HZ / BASE_BAUD;

  localparam logic [1:0] BAUD_SEL_MAX    = 2'h2;
  localparam logic [4:0] CODE_LEN_BASE   = 5'h08;
  localparam logic [2:0] CODE_LEN_DFLT   = 3'h2;
  localparam logic [4:0] POC_MSG_LEN     = 5'h10;
  localparam logic [4:0] POC_TEXT_LEN    = 5'h0e;
  localparam logic [3:0] FRAME_LAST_BIT  = 4'h9;

  localparam logic [7:0] CHAR_CR         = 8'h0d;
  localparam logic [7:0] CHAR_LF         = 8'h0a;
  localparam logic [7:0] CHAR_QMARK      = 8'h3f;
  localparam logic [7:0] CHAR_ZERO       = 8'h30;
  localparam logic [7:0] CHAR_ALPHA_OFS  = 8'h37;
  localparam logic [3:0] NIBBLE_NINE     = 4'h9;

  // Self check texts, fourteen characters each; release text is arbitrary
  localparam logic [111:0] POC_PASS_TEXT = 112'h5245_4144_4552_2052_454c_2031_2e30;
  localparam logic [111:0] POC_FAIL_TEXT = 112'h4641_494c_2020_2020_2020_2020_2020;

  typedef enum logic [1:0] {
    RD_IDLE   = 2'b01,
    RD_ACTIVE = 2'b10
  } ttr_rd_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } ttr_tx_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scan;
  } ttr_host_cmd_t;

  typedef struct packed {
    logic       protocol_mode;
    logic [1:0] baud_sel;
    logic [2:0] code_length_param;
  } ttr_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] code;
  } ttr_tag_t;

endpackage : ttr_pkg

// ---- sim/ttr_reporter_assertions.sv ----
// Port checker for the tag read reporter
`timescale 1ns/100ps
`default_nettype none
module ttr_reporter_assertions #(
  parameter int unsigned READ_CYCLE_CYC_P = 64,
  parameter int unsigned PULSE_CYC_P      = 32,
  parameter int unsigned BIT_CYC_P        = 16
) (
  input wire logic                   sys_clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   trigger_input_a_i,
  input wire logic                   trigger_input_b_i,
  input wire ttr_pkg::ttr_host_cmd_t host_cmd_i,
  input wire ttr_pkg::ttr_cfg_t      cfg_i,
  input wire ttr_pkg::ttr_tag_t      tag_i,
  input wire logic                   read_active_o,
  input wire logic                   antenna_sel_o,
  input wire logic                   read_done_pulse_o,
  input wire logic                   ser_tx_o
);
  int unsigned pulse_q, act_q, low_q, bit_c, pls_c, quiet_q;
  logic [1:0]  bsel;
  assign bsel = (cfg_i.baud_sel == 2'h3) ? 2'h2 : cfg_i.baud_sel;
  assign bit_c = BIT_CYC_P >> bsel;
  assign pls_c = PULSE_CYC_P >> bsel;
  // Run lengths of pulse, read and low line
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_q <= 0;
      act_q <= 0;
      low_q <= 0;
      quiet_q <= 0;
    end else begin
      quiet_q <= (trigger_input_a_i || trigger_input_b_i) ? 0 : quiet_q + 1;
      pulse_q <= read_done_pulse_o ? pulse_q + 1 : 0;
      act_q <= read_active_o ? act_q + 1 : 0;
      low_q <= ser_tx_o ? 0 : low_q + 1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_host_start: assert property (host_cmd_i.start && !read_active_o |=>
    read_active_o && !antenna_sel_o) else $error("host start not taken");
  a_tag_ends: assert property (read_active_o && tag_i.valid |=> !read_active_o)
    else $error("read not ended by tag");
  a_stop_held: assert property (read_active_o && host_cmd_i.stop && act_q < 8 &&
    !tag_i.valid |=> read_active_o) else $error("early stop cut first cycle");
  a_stay_idle: assert property (!read_active_o && !host_cmd_i.start && quiet_q >= 3
    |=> !read_active_o) else $error("read without start");
  a_pulse_width: assert property ($fell(read_done_pulse_o) |-> pulse_q == pls_c)
    else $error("pulse length wrong");
  a_release_pulse: assert property ($fell(trigger_input_a_i) ||
    $fell(trigger_input_b_i) |-> ##[2:20] read_done_pulse_o) else $error("no pulse");
  a_trig_b_ant: assert property ($rose(read_active_o) && trigger_input_b_i &&
    !trigger_input_a_i |-> antenna_sel_o) else $error("trigger b antenna wrong");
  a_char_bits: assert property ($rose(ser_tx_o) |-> low_q > 0 &&
    low_q % bit_c == 0 && low_q <= 9 * bit_c) else $error("bad low run on line");
endmodule : ttr_reporter_assertions
bind ttr_reporter ttr_reporter_assertions #(.READ_CYCLE_CYC_P(READ_CYCLE_CYC_P),
  .PULSE_CYC_P(PULSE_CYC_P), .BIT_CYC_P(BIT_CYC_P)) ttr_reporter_assertions_i (.*);
`default_nettype wire

// ---- sim/ttr_host_rx.sv ----
// Host side serial receiver model
`timescale 1ns/100ps
`default_nettype none
module ttr_host_rx #(
  parameter int unsigned BIT_CYC_P = 16
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ser_tx_i,
  input  wire logic [1:0] baud_sel_i,
  output logic [7:0]      rx_byte_o,
  output logic            rx_stb_o,
  output logic            frame_err_o
);
  int unsigned bc;
  // Always ready, nothing sent back
  always begin
    @(posedge sys_clk_i);
    rx_stb_o <= 1'b0;
    if (sys_rst_i === 1'b0 && ser_tx_i === 1'b0) begin
      bc = BIT_CYC_P >> ((baud_sel_i == 2'h3) ? 2'h2 : baud_sel_i);
      repeat (bc / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bc) @(posedge sys_clk_i);
        rx_byte_o[i] <= ser_tx_i;
      end
      repeat (bc) @(posedge sys_clk_i);
      frame_err_o <= ser_tx_i !== 1'b1;
      rx_stb_o <= 1'b1;
    end
  end
endmodule : ttr_host_rx
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the tag read reporter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned RC = 64;
  localparam int unsigned PC = 32;
  localparam int unsigned BC = 16;
  typedef struct packed {logic [1:0] baud; logic [2:0] cl; logic valid; logic [63:0] code;} ttr_row_t;
  logic                   sys_clk_i, sys_rst_i, trig_a, trig_b, pass, act, ant, pulse, tx, stb, ferr;
  ttr_pkg::ttr_host_cmd_t cmd;
  ttr_pkg::ttr_cfg_t      cfg;
  ttr_pkg::ttr_tag_t      tag;
  logic [7:0]             rxb, rxq[$];
  logic [7:0]             poc_pass[14];
  logic [3:0]             nb;
  int                     err_count, num_checks, n, len;
  ttr_row_t rows[3] = '{'{2'h0, 3'h2, 1'b1, 64'h0123456789abcdef}, '{2'h1, 3'h0, 1'b0, 64'h0},
                        '{2'h3, 3'h7, 1'b1, 64'hfedcba9876543210}};
  ttr_reporter #(.READ_CYCLE_CYC_P(RC), .PULSE_CYC_P(PC), .DEBOUNCE_CYC_P(4), .BIT_CYC_P(BC))
    ttr_reporter_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .trigger_input_a_i(trig_a),
    .trigger_input_b_i(trig_b), .host_cmd_i(cmd), .cfg_i(cfg), .tag_i(tag),
    .self_check_pass_i(pass), .read_active_o(act), .antenna_sel_o(ant),
    .read_done_pulse_o(pulse), .ser_tx_o(tx));
  ttr_host_rx #(.BIT_CYC_P(BC)) ttr_host_rx_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ser_tx_i(tx), .baud_sel_i(cfg.baud_sel), .rx_byte_o(rxb), .rx_stb_o(stb), .frame_err_o(ferr));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask : cyc
  task automatic wait_act(input logic v);
    for (int k = 0; k < 200 && act !== v; k++) cyc(1);
  endtask : wait_act
  task automatic get_msg(input int k);
    for (int j = 0; j < k * 12 * BC && rxq.size() < k; j++) cyc(1);
  endtask : get_msg
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (stb === 1'b1) begin
    rxq.push_back(rxb);
    check(ferr, 1'b0);
  end
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    err_count++;
    complete_run();
  end
  initial begin
    {trig_a, trig_b, cmd, tag} = '0;
    pass = 1'b1;
    cfg = '{1'b0, 2'h0, 3'h2};
    sys_rst_i = 1'b1;
    cyc(2);
    check(tx, 1'b1);
    sys_rst_i = 1'b0;
    get_msg(16);
    check(8'(rxq.size()), 8'h10);
    check(rxq[14], 8'h0d);
    check(rxq[15], 8'h0a);
    check(act, 1'b0);
    foreach (poc_pass[i]) poc_pass[i] = rxq[i];
    foreach (rows[r]) begin
      cfg = '{1'b0, rows[r].baud, rows[r].cl};
      len = 8 + rows[r].cl;
      rxq.delete();
      trig_a = 1'b1;
      wait_act(1'b1);
      check(ant, 1'b0);
      if (rows[r].valid) begin
        tag = '{1'b1, rows[r].code};
        cyc(1);
        tag.valid = 1'b0;
        check(act, 1'b0);
      end
      cyc(3 * RC);
      check(act, !rows[r].valid);
      trig_a = 1'b0;
      for (int k = 0; k < 50 && pulse !== 1'b1; k++) cyc(1);
      for (n = 0; pulse === 1'b1 && n < 99; n++) cyc(1);
      check(8'(n), 8'(PC >> (rows[r].baud == 2'h3 ? 2 : rows[r].baud)));
      get_msg(len + 2);
      check(8'(rxq.size()), 8'(len + 2));
      for (int i = 0; i < len; i++) begin
        nb = rows[r].code[4 * (len - 1 - i) +: 4];
        check(rxq[i], !rows[r].valid ? 8'h3f : nb > 4'h9 ? 8'h37 + nb : 8'h30 + nb);
      end
      check(rxq[len], 8'h0d);
      check(rxq[len + 1], 8'h0a);
    end
    rxq.delete();
    trig_b = 1'b1;
    wait_act(1'b1);
    check(ant, 1'b1);
    cyc(2 * RC);
    trig_b = 1'b0;
    wait_act(1'b0);
    for (int k = 0; k < 50 && pulse !== 1'b1; k++) cyc(1);
    check(pulse, 1'b1);
    cyc(300);
    check(8'(rxq.size()), 8'h0);
    cmd.start = 1'b1;
    cyc(1);
    cmd.start = 1'b0;
    check(act, 1'b1);
    cmd.stop = 1'b1;
    cyc(1);
    cmd.stop = 1'b0;
    cyc(8);
    check(act, 1'b1);
    cyc(RC);
    check(act, 1'b0);
    cmd.start = 1'b1;
    cyc(1);
    cmd.start = 1'b0;
    cyc(RC + 2);
    check(act, 1'b1);
    cmd.stop = 1'b1;
    cyc(1);
    cmd.stop = 1'b0;
    check(act, 1'b0);
    cfg.protocol_mode = 1'b1;
    trig_a = 1'b1;
    wait_act(1'b1);
    tag = '{1'b1, 64'h0};
    cyc(1);
    tag.valid = 1'b0;
    cyc(2 * RC);
    trig_a = 1'b0;
    cyc(400);
    check(8'(rxq.size()), 8'h0);
    cmd.scan = 1'b1;
    cyc(1);
    cmd.scan = 1'b0;
    get_msg(17);
    check(rxq[0], 8'h30);
    check(rxq[16], 8'h0a);
    pass = 1'b0;
    rxq.delete();
    sys_rst_i = 1'b1;
    cyc(2);
    check(tx, 1'b1);
    check(act, 1'b0);
    check(pulse, 1'b0);
    check(ant, 1'b0);
    sys_rst_i = 1'b0;
    cyc(1);
    check(tx, 1'b1);
    cyc(1);
    check(tx, 1'b0);
    get_msg(16);
    n = 0;
    foreach (poc_pass[i]) n += (rxq[i] != poc_pass[i]);
    check(8'(n != 0), 8'h01);
    check(rxq[15], 8'h0a);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
